// File: logic/sacc_pkg.sv
// Purpose: constants shared by the converter control logic
// Assumes: byte-wide register port, register index addressing
// Notes: offsets are byte register indexes on the register port
package sacc_pkg;
    localparam int SACC_AW = 4;
    localparam logic [3:0] SACC_OFS_REFCTL = 4'h0;
    localparam logic [3:0] SACC_OFS_CTL0 = 4'h1;
    localparam logic [3:0] SACC_OFS_CTL1 = 4'h2;
    localparam logic [3:0] SACC_OFS_TRIG = 4'h3;
    localparam logic [3:0] SACC_OFS_RESH = 4'h4;
    localparam logic [3:0] SACC_OFS_RESL = 4'h5;
    localparam logic [3:0] SACC_OFS_IRQ = 4'h6;
    // reference_and_sensor_control fields
    localparam int SACC_REF_EN = 7;
    localparam int SACC_REF_RDY = 6;
    localparam int SACC_SNS_EN = 5;
    localparam int SACC_SNS_RNG = 4;
    // converter_control_zero fields
    localparam int SACC_GO = 1;
    localparam int SACC_ON = 0;
    // converter_control_one fields
    localparam int SACC_FMT = 7;
    localparam int SACC_NREF = 2;
    // interrupt register fields
    localparam int SACC_IRQ_FLAG = 0;
    localparam int SACC_IRQ_AIE = 1;
    localparam int SACC_IRQ_PIE = 2;
    localparam int SACC_IRQ_GIE = 3;
    localparam logic [7:0] SACC_RST_BYTE = 8'h00;
    localparam int SACC_NBITS = 10;
    localparam logic [3:0] SACC_LAST_BIT = 4'h9;
    // system clock rate and a fixed reference settling time
    localparam int SACC_CLK_HZ = 50000000;
    localparam int SACC_REF_SETTLE_NS = 1000;
    localparam int SACC_REF_SETTLE_CYC = (SACC_REF_SETTLE_NS * (SACC_CLK_HZ / 1000000) + 999) / 1000;
    localparam logic [7:0] SACC_REF_SETTLE_CNT = 8'(SACC_REF_SETTLE_CYC);
    // analog source codes on the channel mux
    localparam logic [5:0] SACC_CH_GND = 6'h3B;
    localparam logic [5:0] SACC_CH_TEMP = 6'h3C;
    localparam logic [5:0] SACC_CH_DAC = 6'h3D;
    localparam logic [5:0] SACC_CH_FIX1 = 6'h3E;
    localparam logic [5:0] SACC_CH_FIX2 = 6'h3F;
    typedef enum logic [3:0] {
        SACC_IDLE = 4'b0001,
        SACC_DELAY = 4'b0010,
        SACC_SAMPLE = 4'b0100,
        SACC_CONV = 4'b1000
    } sacc_state_e;
endpackage

// File: logic/sacc_top.sv
// Purpose: control of a 10-bit successive-approximation converter
// Assumes: comparator result arrives from the analog front end as a pin
// Notes: one clock; the rc bit clock is sampled as a pin
//
// Function
// R1: build a 10-bit value by successive approximation; store in result pair
// R2: six-bit channel field routes one analog source to sample-and-hold
// R3: sources are port channels, temperature sensor, dac, fixed reference, ground
// R4: software waits an acquisition delay after a channel change
// R5: two-bit field picks positive reference: pin, supply, 2.048V, 4.096V
// R6: negative reference is either its pin or ground
// R7: three-bit field picks divide 2..64 or the rc oscillator for x11
// R8: a full conversion lasts 11.5 bit periods
// R9: divided clocks follow system clock; only rc source is independent
// R10: conversion continues in sleep only with the rc clock
// R11: completion flag set at every conversion end, regardless of enable
// R12: completion flag stays set until software clears it
// R13: enabled completion interrupt wakes a sleeping device
// R14: after waking, the instruction after sleep runs first
// R15: all three enables vector to the handler; global clear resumes in line
// R16: format bit picks left or right justified result
// R17: range bit selects high sensor range when set, low when clear
// R18: two factory sensor readings, one per range, kept for calibration
// R19: start bit works only with converter already on, not same write
// R20: on finish clear busy, set flag, load result registers
// R21: software abort loads partial value, unresolved bits copy last bit
// R22: rc clock starts one instruction late; other clocks abort on sleep
// R23: right justify puts two upper bits low in high byte
// R24: bits resolved msb first, one per period, after half-period sample
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module sacc_top
    import sacc_pkg::*;
#(
    parameter int INSTR_CYC = 4,
    parameter logic [9:0] CAL_LOW = 10'h000,
    parameter logic [9:0] CAL_HIGH = 10'h000
)(
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic [sacc_pkg::SACC_AW-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_sleep,
    input wire logic i_rc_clk,
    input wire logic i_cmp,
    input wire logic i_low_voltage,
    output logic [5:0] o_channel_select,
    output logic [1:0] o_positive_reference_select,
    output logic o_negative_reference_pin,
    output logic o_sample,
    output logic [9:0] o_dac_code,
    output logic o_sensor_enable,
    output logic o_sensor_range_select,
    output logic o_fixed_reference_enable,
    output logic [1:0] o_converter_ref_gain,
    output logic [1:0] o_comparator_ref_gain,
    output logic o_wake,
    output logic o_vector
);
    import sacc_pkg::*;

    logic [7:0] refctl_q, ctl0_q, ctl1_q, trig_q, resh_q, resl_q;
    logic [3:0] irq_q;
    logic [7:0] rdata_d, rdata_q;
    logic [7:0] ref_cnt_q;
    logic rc_s1_q, rc_s2_q, rc_s3_q;
    logic [6:0] div_q;
    logic tick;
    logic [7:0] delay_q;
    logic [3:0] bit_q;
    logic [9:0] sar_q;
    logic [9:0] dec_q;
    logic half_q;
    logic cmp_s1_q, cmp_s2_q;
    logic abort_q;
    sacc_state_e state_q;

    // write decode
    wire wr_ctl0 = i_wr && (i_addr == SACC_OFS_CTL0);
    wire wr_irq = i_wr && (i_addr == SACC_OFS_IRQ);
    wire wr_refctl = i_wr && (i_addr == SACC_OFS_REFCTL);
    wire wr_ctl1 = i_wr && (i_addr == SACC_OFS_CTL1);
    wire wr_trig = i_wr && (i_addr == SACC_OFS_TRIG);
    wire wr_resh = i_wr && (i_addr == SACC_OFS_RESH);
    wire wr_resl = i_wr && (i_addr == SACC_OFS_RESL);
    wire use_rc = ctl1_q[5:4] == 2'b11; // [R7]
    wire busy = ctl0_q[SACC_GO];
    // half-period sample, ten bit periods, then one closing period: 11.5 in all
    // the result is final once all ten bits are resolved
    wire done_evt = (state_q == SACC_CONV) && tick && half_q && (bit_q == 4'(SACC_NBITS)); // [R8]
    wire sw_abort = wr_ctl0 && busy && !i_wdata[SACC_GO] && (state_q != SACC_IDLE);
    wire sleep_abort = i_sleep && !use_rc && (state_q != SACC_IDLE); // [R22]
    wire fin = done_evt || sw_abort;
    // start only when on before this write
    wire start_req = wr_ctl0 && i_wdata[SACC_GO] && ctl0_q[SACC_ON] && i_wdata[SACC_ON]; // [R19]
    wire irq_pend = irq_q[SACC_IRQ_FLAG] && irq_q[SACC_IRQ_AIE] && irq_q[SACC_IRQ_PIE];

    function automatic logic [9:0] fill_partial(input logic [9:0] v, input logic [3:0] n);
        logic [9:0] r;
        logic last;
        r = v;
        last = (n == 4'h0) ? 1'b0 : v[4'd10 - n];
        for (int k = 0; k < 10; k++)
        begin
            if (k < (10 - int'(n)))
            begin
                r[k] = last; // [R21]
            end
        end
        return r;
    endfunction

    // rc and comparator pin synchronisers, rc edge
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rc_s1_q <= 1'b0;
            rc_s2_q <= 1'b0;
            rc_s3_q <= 1'b0;
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
        end
        else
        begin
            rc_s1_q <= i_rc_clk;
            rc_s2_q <= rc_s1_q;
            rc_s3_q <= rc_s2_q;
            cmp_s1_q <= i_cmp;
            cmp_s2_q <= cmp_s1_q;
        end
    end

    // half-period tick: divided system clock or rc edges
    wire [6:0] div_lim = (ctl1_q[5:4] == 2'b00) ? 7'd0 : (ctl1_q[5:4] == 2'b01) ? 7'd3 : 7'd15;
    wire [6:0] div_top = ctl1_q[6] ? (7'(div_lim << 1) + 7'd1) : div_lim; // [R7]
    assign tick = use_rc ? (rc_s2_q != rc_s3_q) : (div_q >= div_top); // [R9]

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            div_q <= 7'd0;
        else if (tick || state_q == SACC_IDLE)
            div_q <= 7'd0;
        else
            div_q <= div_q + 7'd1;
    end

    // conversion sequencer
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_q <= SACC_IDLE;
            delay_q <= 8'h00;
            bit_q <= 4'h0;
            sar_q <= 10'h000;
            dec_q <= 10'h000;
            half_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                SACC_IDLE:
                begin
                    if (start_req)
                    begin
                        state_q <= use_rc ? SACC_DELAY : SACC_SAMPLE;
                        delay_q <= 8'(INSTR_CYC); // [R22]
                        half_q <= 1'b0;
                    end
                end
                SACC_DELAY:
                begin
                    if (fin || sleep_abort)
                        state_q <= SACC_IDLE;
                    else if (delay_q == 8'h00)
                        state_q <= SACC_SAMPLE;
                    else
                        delay_q <= delay_q - 8'h01;
                end
                SACC_SAMPLE:
                begin
                    if (fin || sleep_abort)
                        state_q <= SACC_IDLE;
                    else if (tick)
                    begin
                        state_q <= SACC_CONV; // [R24]
                        bit_q <= 4'h0;
                        half_q <= 1'b0;
                        sar_q <= 10'h200;
                        dec_q <= 10'h000;
                    end
                end
                SACC_CONV:
                begin
                    if (fin || sleep_abort)
                        state_q <= SACC_IDLE; // [R8]
                    else if (tick)
                    begin
                        half_q <= !half_q;
                        if (half_q)
                        begin
                            // keep trial bit when input is above the trial level
                            dec_q <= dec_q | (sar_q & {10{cmp_s2_q}}); // [R1] [R24]
                            sar_q <= sar_q >> 1;
                            bit_q <= bit_q + 4'h1;
                        end
                    end
                end
                default:
                    state_q <= SACC_IDLE;
            endcase
        end
    end

    // every trial bit is decided before the closing period starts
    wire [9:0] final_val = dec_q;
    wire [9:0] result = done_evt ? final_val : fill_partial(dec_q, bit_q);
    wire right_just = ctl1_q[SACC_FMT]; // [R16]
    wire [7:0] res_hi = right_just ? {6'h00, result[9:8]} : result[9:2]; // [R23]
    wire [7:0] res_lo = right_just ? result[7:0] : {result[1:0], 6'h00};

    // register file
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            refctl_q <= SACC_RST_BYTE;
            ctl0_q <= SACC_RST_BYTE;
            ctl1_q <= SACC_RST_BYTE;
            trig_q <= SACC_RST_BYTE;
            resh_q <= SACC_RST_BYTE;
            resl_q <= SACC_RST_BYTE;
            irq_q <= 4'h0;
            ref_cnt_q <= 8'h00;
            abort_q <= 1'b0;
        end
        else
        begin
            abort_q <= sleep_abort;
            if (wr_refctl)
                refctl_q <= {i_wdata[7], 1'b0, i_wdata[5:0]}; // [R17]
            if (wr_ctl1)
                ctl1_q <= {i_wdata[7:4], 1'b0, i_wdata[2:0]};
            if (wr_trig)
                trig_q <= {4'h0, i_wdata[3:0]};
            if (wr_ctl0)
                ctl0_q <= {i_wdata[7:2], start_req || (busy && i_wdata[SACC_GO]), i_wdata[SACC_ON]}; // [R2]
            if (fin || sleep_abort)
                ctl0_q[SACC_GO] <= 1'b0; // [R20]
            if (fin)
            begin
                resh_q <= res_hi;
                resl_q <= res_lo;
            end
            else
            begin
                if (wr_resh)
                    resh_q <= i_wdata;
                if (wr_resl)
                    resl_q <= i_wdata;
            end
            if (wr_irq)
                irq_q <= i_wdata[3:0];
            if (done_evt || (wr_irq && irq_q[SACC_IRQ_FLAG] && i_wdata[SACC_IRQ_FLAG]))
                irq_q[SACC_IRQ_FLAG] <= 1'b1; // [R11] [R12]
            if (!refctl_q[SACC_REF_EN])
                ref_cnt_q <= 8'h00;
            else if (ref_cnt_q != SACC_REF_SETTLE_CNT)
                ref_cnt_q <= ref_cnt_q + 8'h01;
        end
    end

    // read mux
    wire ref_ready = i_low_voltage || (ref_cnt_q == SACC_REF_SETTLE_CNT);

    // factory sensor readings, one pair of bytes per range
    wire [7:0] cal_low_lo = CAL_LOW[7:0];
    wire [7:0] cal_low_hi = {6'h00, CAL_LOW[9:8]};
    wire [7:0] cal_high_lo = CAL_HIGH[7:0];
    wire [7:0] cal_high_hi = {6'h00, CAL_HIGH[9:8]};
    always_comb
    begin
        rdata_d = 8'h00;
        unique case (i_addr)
            SACC_OFS_REFCTL: rdata_d = {refctl_q[7], ref_ready, refctl_q[5:0]};
            SACC_OFS_CTL0: rdata_d = ctl0_q;
            SACC_OFS_CTL1: rdata_d = ctl1_q;
            SACC_OFS_TRIG: rdata_d = trig_q;
            SACC_OFS_RESH: rdata_d = resh_q;
            SACC_OFS_RESL: rdata_d = resl_q;
            SACC_OFS_IRQ: rdata_d = {4'h0, irq_q};
            4'h7: rdata_d = cal_low_lo; // [R18]
            4'h8: rdata_d = cal_low_hi;
            4'h9: rdata_d = cal_high_lo;
            4'hA: rdata_d = cal_high_hi;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rdata_q <= 8'h00;
            o_channel_select <= 6'h00;
            o_positive_reference_select <= 2'b00;
            o_negative_reference_pin <= 1'b0;
            o_sample <= 1'b0;
            o_dac_code <= 10'h000;
            o_sensor_enable <= 1'b0;
            o_sensor_range_select <= 1'b0;
            o_fixed_reference_enable <= 1'b0;
            o_converter_ref_gain <= 2'b00;
            o_comparator_ref_gain <= 2'b00;
            o_wake <= 1'b0;
            o_vector <= 1'b0;
        end
        else
        begin
            rdata_q <= i_rd ? rdata_d : 8'h00;
            o_channel_select <= ctl0_q[7:2]; // [R2] [R3]
            // 4.096V choice falls back to 2.048V on low-voltage parts
            o_positive_reference_select <= (i_low_voltage && ctl1_q[1:0] == 2'b11) ? 2'b10 : ctl1_q[1:0]; // [R5]
            o_negative_reference_pin <= ctl1_q[SACC_NREF]; // [R6]
            o_sample <= ctl0_q[SACC_ON] && !abort_q && (state_q == SACC_SAMPLE || state_q == SACC_IDLE); // [R10]
            o_dac_code <= dec_q | sar_q;
            o_sensor_enable <= refctl_q[SACC_SNS_EN];
            o_sensor_range_select <= refctl_q[SACC_SNS_RNG]; // [R17]
            o_fixed_reference_enable <= refctl_q[SACC_REF_EN];
            o_converter_ref_gain <= refctl_q[1:0];
            o_comparator_ref_gain <= refctl_q[3:2];
            o_wake <= i_sleep && irq_pend; // [R13] [R14]
            o_vector <= irq_pend && irq_q[SACC_IRQ_GIE]; // [R15]
        end
    end

    assign o_rdata = rdata_q;
endmodule

// File: testbench/sacc_top_monitor.sv
// Purpose: port checks for the converter control
// Assumes: one clock, async active-low reset
// Notes: control outputs trail a write by two edges
`timescale 1ns/1ps
module sacc_top_monitor
    import sacc_pkg::*;
#(
    parameter logic [9:0] CAL_LOW = 10'h000,
    parameter logic [9:0] CAL_HIGH = 10'h000
)(
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic i_sleep,
    input wire logic i_low_voltage,
    input wire logic [5:0] o_channel_select,
    input wire logic [1:0] o_positive_reference_select,
    input wire logic o_negative_reference_pin,
    input wire logic o_sensor_range_select,
    input wire logic o_wake,
    input wire logic o_vector
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    wire w_ctl0 = i_wr && i_addr == SACC_OFS_CTL0;
    wire w_ctl1 = i_wr && i_addr == SACC_OFS_CTL1;
    wire w_ref = i_wr && i_addr == SACC_OFS_REFCTL;
    wire r_irq = i_rd && i_addr == SACC_OFS_IRQ;
    chan_follow_a: assert property (w_ctl0 |-> ##2 o_channel_select == $past(i_wdata[7:2], 2))
        else $error("channel output does not follow write");
    posref_follow_a: assert property (w_ctl1 && !i_low_voltage |-> ##2 o_positive_reference_select == $past(i_wdata[1:0], 2))
        else $error("positive reference output does not follow write");
    negref_follow_a: assert property (w_ctl1 |-> ##2 o_negative_reference_pin == $past(i_wdata[SACC_NREF], 2))
        else $error("negative reference output does not follow write");
    range_follow_a: assert property (w_ref |-> ##2 o_sensor_range_select == $past(i_wdata[SACC_SNS_RNG], 2))
        else $error("sensor range output does not follow write");
    wake_cause_a: assert property ($past(r_irq) |-> o_wake == ($past(i_sleep) && (&o_rdata[2:0])))
        else $error("wake level disagrees with flag and enables");
    vector_cause_a: assert property ($past(r_irq) |-> o_vector == (&o_rdata[3:0]))
        else $error("vector level disagrees with flag and enables");
    wake_asleep_a: assert property (o_wake |-> $past(i_sleep))
        else $error("wake raised while awake");
    factory_read_a: assert property ($past(i_rd) && $past(i_addr) == 4'h7 |-> o_rdata == CAL_LOW[7:0])
        else $error("low range factory reading wrong");
endmodule
bind sacc_top sacc_top_monitor #(.CAL_LOW(CAL_LOW), .CAL_HIGH(CAL_HIGH)) mon_u (.i_mclk(i_mclk),
    .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_sleep(i_sleep), .i_low_voltage(i_low_voltage), .o_channel_select(o_channel_select),
    .o_positive_reference_select(o_positive_reference_select), .o_negative_reference_pin(o_negative_reference_pin),
    .o_sensor_range_select(o_sensor_range_select), .o_wake(o_wake), .o_vector(o_vector));

// File: testbench/sacc_analog_model.sv
// Purpose: analog side: comparator and rc oscillator
// Assumes: fixed input level
// Notes: half-lsb offset keeps every trial off a tie
`timescale 1ns/1ps
module sacc_analog_model #(
    parameter logic [9:0] LEVEL = 10'h2B6
)(
    input wire logic [9:0] i_dac_code,
    output logic o_cmp,
    output logic o_rc_clk
);
    assign o_cmp = {LEVEL, 1'b1} > {i_dac_code, 1'b0};
    initial
    begin
        o_rc_clk = 1'b0;
        forever
            #100 o_rc_clk = ~o_rc_clk;
    end
endmodule

// File: testbench/sacc_top_tb.sv
// Purpose: self-checking bench for the converter control
// Assumes: register port, fixed analog level
// Notes: one task per scenario
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module sacc_top_tb;
    import sacc_pkg::*;
    localparam logic [9:0] LVL = 10'h2B6;
    localparam logic [9:0] CAL_LO = 10'h155;
    logic i_mclk, i_reset_n, i_wr, i_rd, i_sleep, cmp, rc, o_nref, o_rng, o_wake, o_vector, lv;
    logic [3:0] i_addr;
    logic [7:0] i_wdata, o_rdata, rv;
    logic [5:0] o_chan;
    logic [1:0] o_pref;
    logic [9:0] dac;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    int t;
    initial
    begin
        i_mclk = 1'b0;
        forever
            #10 i_mclk = ~i_mclk;
    end
    sacc_top #(.CAL_LOW(CAL_LO), .CAL_HIGH(10'h2AA)) dut_u (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep(i_sleep),
        .i_rc_clk(rc), .i_cmp(cmp), .i_low_voltage(lv), .o_channel_select(o_chan),
        .o_positive_reference_select(o_pref), .o_negative_reference_pin(o_nref), .o_sample(), .o_dac_code(dac),
        .o_sensor_enable(), .o_sensor_range_select(o_rng), .o_fixed_reference_enable(),
        .o_converter_ref_gain(), .o_comparator_ref_gain(), .o_wake(o_wake), .o_vector(o_vector));
    sacc_analog_model #(.LEVEL(LVL)) model_u (.i_dac_code(dac), .o_cmp(cmp), .o_rc_clk(rc));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge i_mclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 rv = o_rdata;
    endtask
    task automatic start_wait();
        wr(SACC_OFS_CTL0, {SACC_CH_TEMP, 2'b11});
        t = 0;
        rd(SACC_OFS_CTL0);
        while (rv[SACC_GO] !== 1'b0 && t < 400)
        begin
            rd(SACC_OFS_CTL0);
            t++;
        end
        `CHK(rv[SACC_GO], 1'b0)
    endtask
    task automatic t_reset_and_start();
        for (int i = 0; i < 7; i++)
        begin
            rd(i[3:0]);
            `CHK(rv, SACC_RST_BYTE)
        end
        rd(4'hF);
        `CHK(rv, 8'h00)
        wr(SACC_OFS_CTL0, 8'h03);
        rd(SACC_OFS_CTL0);
        `CHK(rv, 8'h01)
        repeat (20) @(posedge i_mclk);
    endtask
    task automatic t_divided_clocks();
        logic [2:0] sel [6] = '{3'b000, 3'b100, 3'b001, 3'b101, 3'b010, 3'b110};
        for (int i = 0; i < 6; i++)
        begin
            wr(SACC_OFS_CTL1, {1'b0, sel[i], 4'h0});
            start_wait();
            `CHK((2 * t >= (23 << i) - 1) && (2 * t <= (23 << i)), 1'b1)
        end
        rd(SACC_OFS_IRQ);
        `CHK(rv[SACC_IRQ_FLAG], 1'b1)
        rd(SACC_OFS_RESH);
        `CHK(rv, LVL[9:2])
        rd(SACC_OFS_RESL);
        `CHK(rv, {LVL[1:0], 6'h00})
        repeat (50) @(posedge i_mclk);
        rd(SACC_OFS_IRQ);
        `CHK(rv[SACC_IRQ_FLAG], 1'b1)
    endtask
    task automatic t_rc_sleep_wake();
        wr(SACC_OFS_IRQ, 8'h06);
        wr(SACC_OFS_CTL1, 8'hB0);
        wr(SACC_OFS_CTL0, {SACC_CH_TEMP, 2'b11});
        i_sleep <= 1'b1;
        t = 0;
        while (o_wake !== 1'b1 && t < 600)
        begin
            @(posedge i_mclk);
            #1;
            t++;
        end
        `CHK(o_wake, 1'b1)
        `CHK(o_vector, 1'b0)
        @(posedge i_mclk);
        i_sleep <= 1'b0;
        rd(SACC_OFS_RESH);
        `CHK(rv, {6'h00, LVL[9:8]})
        rd(SACC_OFS_RESL);
        `CHK(rv, LVL[7:0])
        wr(SACC_OFS_IRQ, 8'h0F);
        repeat (3) @(posedge i_mclk);
        `CHK(o_vector, 1'b1)
        wr(SACC_OFS_IRQ, 8'h0E);
        repeat (3) @(posedge i_mclk);
        `CHK(o_vector, 1'b0)
    endtask
    task automatic t_sleep_abort();
        wr(SACC_OFS_IRQ, 8'h00);
        wr(SACC_OFS_CTL1, 8'h60);
        wr(SACC_OFS_CTL0, {SACC_CH_TEMP, 2'b11});
        repeat (30) @(posedge i_mclk);
        i_sleep <= 1'b1;
        repeat (4) @(posedge i_mclk);
        i_sleep <= 1'b0;
        rd(SACC_OFS_CTL0);
        `CHK(rv, {SACC_CH_TEMP, 2'b01})
        rd(SACC_OFS_IRQ);
        `CHK(rv[SACC_IRQ_FLAG], 1'b0)
    endtask
    task automatic t_sw_abort();
        logic [9:0] part;
        part = {LVL[9:7], {7{LVL[7]}}};
        wr(SACC_OFS_CTL1, 8'h60);
        wr(SACC_OFS_CTL0, {SACC_CH_TEMP, 2'b11});
        repeat (250) @(posedge i_mclk);
        wr(SACC_OFS_CTL0, {SACC_CH_TEMP, 2'b01});
        rd(SACC_OFS_RESH);
        `CHK(rv, part[9:2])
        rd(SACC_OFS_RESL);
        `CHK(rv, {part[1:0], 6'h00})
    endtask
    task automatic t_outputs();
        for (int p = 0; p < 4; p++)
        begin
            wr(SACC_OFS_CTL1, {5'h00, p[0], p[1:0]});
            repeat (3) @(posedge i_mclk);
            `CHK(o_pref, p[1:0])
            `CHK(o_nref, p[0])
        end
        wr(SACC_OFS_REFCTL, 8'h30);
        repeat (3) @(posedge i_mclk);
        `CHK(o_rng, 1'b1)
        `CHK(o_chan, SACC_CH_TEMP)
        @(posedge i_mclk);
        lv <= 1'b1;
        wr(SACC_OFS_CTL1, 8'h03);
        repeat (3) @(posedge i_mclk);
        `CHK(o_pref, 2'b10)
        rd(SACC_OFS_REFCTL);
        `CHK(rv[SACC_REF_RDY], 1'b1)
        @(posedge i_mclk);
        lv <= 1'b0;
        rd(4'h7);
        `CHK(rv, CAL_LO[7:0])
        rd(4'h9);
        `CHK(rv, 8'hAA)
    endtask
    initial
    begin
        i_reset_n = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_sleep = 1'b0;
        lv = 1'b0;
        i_addr = 4'h0;
        i_wdata = 8'h00;
        repeat (10) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        t_reset_and_start();
        t_divided_clocks();
        t_rc_sleep_wake();
        t_sleep_abort();
        t_sw_abort();
        t_outputs();
        give_verdict();
    end
endmodule
